// [hdl/bcai_codec_end.sv]
`timescale 1ns/10ps
`default_nettype none
`include "bcai_consts.svh"
module bcai_codec_end (
  input  wire logic                     clk,                // 50 MHz clock
  input  wire logic                     sys_rst,            // async reset, high
  input  wire logic                     rfTick,             // one pulse per 13 MHz edge
  input  wire logic                     hookDetectInput,    // hook detect level
  input  wire logic                     headsetDetectInput, // headset detect level
  input  wire logic                     detectIrqEnable,    // detect interrupt enable
  input  wire logic [`BCAI_SAMPLE_W-1:0] upSample,          // uplink sample to send
  input  wire logic                     wordLoad,           // local word write strobe
  input  wire logic [`BCAI_ADDR_W-1:0]  wordIndex,          // local word index
  input  wire logic [`BCAI_DATA_W-1:0]  wordValue,          // local word value
  output logic      [`BCAI_SAMPLE_W-1:0] downSample,        // received downlink sample
  output logic                          downValid,          // downlink sample pulse
  output logic                          ctrlUpdate,         // bus write pulse
  output logic      [`BCAI_ADDR_W-1:0]  ctrlIndex,          // written word index
  output logic      [`BCAI_DATA_W-1:0]  ctrlValue,          // written word value
  output logic                          accessoryIrq,       // accessory change pulse
  output bcai_pkg::bcai_accessory_t     accessory,          // decoded accessory state
  bcai_link_if.codec                    lnk                 // link to the DSP end
);

  // serial timing state
  logic [3:0]                 divCnt;
  logic [3:0]                 next_divCnt;
  logic [6:0]                 slot;
  logic [6:0]                 next_slot;
  logic                       bitClock;
  logic                       next_bitClock;
  logic                       frameSync;
  logic                       next_frameSync;
  logic                       txLine;
  logic                       next_txLine;
  logic [`BCAI_SAMPLE_W-1:0] txShift;
  logic [`BCAI_SAMPLE_W-1:0] next_txShift;
  logic [`BCAI_SAMPLE_W-1:0] rxShift;
  logic [`BCAI_SAMPLE_W-1:0] next_rxShift;
  logic [`BCAI_SAMPLE_W-1:0] next_downSample;
  logic                       next_downValid;
  logic                       slotEnd;
  logic                       dataSlot;

  assign slotEnd  = rfTick && (divCnt == `BCAI_DIV_LAST);
  assign dataSlot = (slot >= `BCAI_SLOT_FIRST) && (slot <= `BCAI_SLOT_LAST);

  // bit clock, frame sync and sample shifting
  always_comb begin
    next_divCnt     = divCnt;
    next_slot       = slot;
    next_bitClock   = bitClock;
    next_frameSync  = frameSync;
    next_txLine     = txLine;
    next_txShift    = txShift;
    next_rxShift    = rxShift;
    next_downSample = downSample;
    next_downValid  = 1'b0;
    if (rfTick) begin
      next_divCnt = slotEnd ? `BCAI_DIV_FIRST : divCnt + 4'h1;       // see RULE1
      if (slotEnd) begin
        next_bitClock = 1'b1;                                       // see RULE1
        next_slot     = (slot == `BCAI_FRAME_LAST) ? `BCAI_SLOT_SYNC
                                                   : slot + 7'h01;  // see RULE2
        next_frameSync = (slot == `BCAI_FRAME_LAST);                // see RULE2
        if (slot == `BCAI_FRAME_LAST) begin
          next_txShift = upSample;                                  // see RULE7
          next_txLine  = 1'b0;
        end else if (slot < `BCAI_SLOT_LAST) begin
          next_txLine  = txShift[`BCAI_SAMPLE_W-1];                 // see RULE11
          next_txShift = {txShift[`BCAI_SAMPLE_W-2:0], 1'b0};
        end else begin
          next_txLine = 1'b0;
        end
      end else if (divCnt == `BCAI_DIV_HIGH - 4'h1) begin
        next_bitClock = 1'b0;                                       // see RULE1
        if (dataSlot) begin
          next_rxShift = {rxShift[`BCAI_SAMPLE_W-2:0], lnk.codecRxLine}; // see RULE11
          if (slot == `BCAI_SLOT_LAST) begin
            next_downSample = {rxShift[`BCAI_SAMPLE_W-2:0], lnk.codecRxLine};
            next_downValid  = 1'b1;                                 // see RULE7
          end
        end
      end
    end
  end

  // serial state registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      divCnt     <= `BCAI_DIV_FIRST;
      slot       <= `BCAI_FRAME_LAST;  // first slot after reset carries sync
      bitClock   <= 1'b0;
      frameSync  <= 1'b0;
      txLine     <= 1'b0;
      txShift    <= `BCAI_SAMPLE_ZERO;
      rxShift    <= `BCAI_SAMPLE_ZERO;
      downSample <= `BCAI_SAMPLE_ZERO;
      downValid  <= 1'b0;
    end else begin
      divCnt     <= next_divCnt;
      slot       <= next_slot;
      bitClock   <= next_bitClock;
      frameSync  <= next_frameSync;
      txLine     <= next_txLine;
      txShift    <= next_txShift;
      rxShift    <= next_rxShift;
      downSample <= next_downSample;
      downValid  <= next_downValid;
    end
  end

  // both serial clocks leave this end as outputs
  assign lnk.pcmBitClock  = bitClock;   // see RULE3
  assign lnk.pcmFrameSync = frameSync;  // see RULE3
  assign lnk.codecTxLine  = txLine;     // see RULE4

  // parallel bus state
  logic [`BCAI_DATA_W-1:0]   words [`BCAI_WORDS];
  bcai_pkg::bcai_codec_bus_t busState;
  bcai_pkg::bcai_codec_bus_t next_busState;
  logic                      ackN;
  logic                      next_ackN;
  logic [`BCAI_DATA_W-1:0]  dataOut;
  logic [`BCAI_DATA_W-1:0]  next_dataOut;
  logic                      dataOe;
  logic                      next_dataOe;
  logic                      next_ctrlUpdate;
  logic [`BCAI_ADDR_W-1:0]  next_ctrlIndex;
  logic [`BCAI_DATA_W-1:0]  next_ctrlValue;

  // strobe handshake: acknowledge low until both strobes return high
  always_comb begin
    next_busState   = busState;
    next_ackN       = ackN;
    next_dataOut    = dataOut;
    next_dataOe     = dataOe;
    next_ctrlUpdate = 1'b0;
    next_ctrlIndex  = ctrlIndex;
    next_ctrlValue  = ctrlValue;
    case (busState)
      bcai_pkg::BCAI_BUS_IDLE: begin
        if (!lnk.wrN) begin
          next_ackN       = 1'b0;                                   // see RULE5
          next_ctrlUpdate = 1'b1;                                   // see RULE6
          next_ctrlIndex  = lnk.busAddr;
          next_ctrlValue  = lnk.busData;
          next_busState   = bcai_pkg::BCAI_BUS_ACK;
        end else if (!lnk.rdN) begin
          next_ackN     = 1'b0;                                     // see RULE5
          next_dataOut  = words[lnk.busAddr];                       // see RULE6
          next_dataOe   = 1'b1;
          next_busState = bcai_pkg::BCAI_BUS_ACK;
        end
      end
      bcai_pkg::BCAI_BUS_ACK: begin
        if (lnk.rdN && lnk.wrN) begin
          next_ackN     = 1'b1;
          next_dataOe   = 1'b0;
          next_busState = bcai_pkg::BCAI_BUS_IDLE;
        end
      end
      default: begin
        next_ackN     = 1'b1;
        next_dataOe   = 1'b0;
        next_busState = bcai_pkg::BCAI_BUS_IDLE;
      end
    endcase
  end

  // bus state registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busState   <= bcai_pkg::BCAI_BUS_IDLE;
      ackN       <= 1'b1;
      dataOut    <= `BCAI_DATA_ZERO;
      dataOe     <= 1'b0;
      ctrlUpdate <= 1'b0;
      ctrlIndex  <= `BCAI_ADDR_ZERO;
      ctrlValue  <= `BCAI_DATA_ZERO;
    end else begin
      busState   <= next_busState;
      ackN       <= next_ackN;
      dataOut    <= next_dataOut;
      dataOe     <= next_dataOe;
      ctrlUpdate <= next_ctrlUpdate;
      ctrlIndex  <= next_ctrlIndex;
      ctrlValue  <= next_ctrlValue;
    end
  end

  // word store: a bus write wins over a local load of the same word
  generate
    for (genvar w = 0; w < `BCAI_WORDS; w++) begin : g_word
      logic [`BCAI_DATA_W-1:0] next_word;
      always_comb begin
        next_word = words[w];
        if (wordLoad && (wordIndex == w[`BCAI_ADDR_W-1:0]))
          next_word = wordValue;
        if (next_ctrlUpdate && (lnk.busAddr == w[`BCAI_ADDR_W-1:0]))
          next_word = lnk.busData;                                  // see RULE6
      end
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
          words[w] <= `BCAI_DATA_ZERO;
        else
          words[w] <= next_word;
      end
    end
  endgenerate

  assign lnk.ackN         = ackN;
  assign lnk.codecDataOut = dataOut;
  assign lnk.codecDataOe  = dataOe;

  // accessory detection
  logic                      hookPrev;
  logic                      headPrev;
  logic                      next_accessoryIrq;
  bcai_pkg::bcai_accessory_t next_accessory;

  always_comb begin
    case ({hookDetectInput, headsetDetectInput})
      2'h3:    next_accessory = bcai_pkg::BCAI_ACC_NONE;            // see RULE9
      2'h0:    next_accessory = bcai_pkg::BCAI_ACC_PRESSED;         // see RULE9
      2'h2:    next_accessory = bcai_pkg::BCAI_ACC_RELEASED;        // see RULE9
      default: next_accessory = bcai_pkg::BCAI_ACC_UNKNOWN;
    endcase
    next_accessoryIrq = detectIrqEnable &&                          // see RULE10
                        ((hookDetectInput != hookPrev) ||           // see RULE8
                         (headsetDetectInput != headPrev));
  end

  // detect registers; both lines idle high through the pull-ups
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hookPrev     <= 1'b1;
      headPrev     <= 1'b1;
      accessory    <= bcai_pkg::BCAI_ACC_NONE;
      accessoryIrq <= 1'b0;
    end else begin
      hookPrev     <= hookDetectInput;
      headPrev     <= headsetDetectInput;
      accessory    <= next_accessory;
      accessoryIrq <= next_accessoryIrq;
    end
  end

endmodule : bcai_codec_end
`default_nettype wire

// [common/bcai_consts.svh]
// Overview of operation
// RULE1 - codec divides 13 MHz clock by thirteen
// RULE2 - frame sync is bit clock over 125
// RULE3 - codec makes both clocks; DSP is slave
// RULE4 - four serial wires carry only PCM samples
// RULE5 - twelve data, four address, strobes, acknowledge
// RULE6 - parallel bus carries control words and samples; here it carries control words only, samples go over the serial lines
// RULE7 - DSP writes downlink, reads uplink speech blocks
// RULE8 - hook changes raise interrupt both ways
// RULE9 - decode hook and headset detect levels
// RULE10 - disable detect interrupt during call
// RULE11 - 16-bit words, MSB first after sync
`ifndef BCAI_CONSTS_SVH
`define BCAI_CONSTS_SVH
`define BCAI_RF_DIV      4'hD
`define BCAI_DIV_LAST    4'hC
`define BCAI_DIV_HIGH    4'h6
`define BCAI_DIV_FIRST   4'h0
`define BCAI_FRAME_LAST  7'h7C
`define BCAI_SLOT_SYNC   7'h00
`define BCAI_SLOT_FIRST  7'h01
`define BCAI_SLOT_LAST   7'h10
`define BCAI_SAMPLE_W    16
`define BCAI_DATA_W      12
`define BCAI_ADDR_W      4
`define BCAI_WORDS       16
`define BCAI_DATA_IDLE   12'hFFF
`define BCAI_SAMPLE_ZERO 16'h0000
`define BCAI_DATA_ZERO   12'h000
`define BCAI_ADDR_ZERO   4'h0
`endif

// [common/bcai_pkg.sv]
package bcai_pkg;
  typedef enum logic [1:0] {
    BCAI_BUS_IDLE = 2'h1,
    BCAI_BUS_ACK  = 2'h2
  } bcai_codec_bus_t;
  typedef enum logic [2:0] {
    BCAI_DSP_IDLE    = 3'h1,
    BCAI_DSP_STROBE  = 3'h2,
    BCAI_DSP_RELEASE = 3'h4
  } bcai_dsp_bus_t;
  typedef enum logic [3:0] {
    BCAI_ACC_NONE     = 4'h1,
    BCAI_ACC_PRESSED  = 4'h2,
    BCAI_ACC_RELEASED = 4'h4,
    BCAI_ACC_UNKNOWN  = 4'h8
  } bcai_accessory_t;
endpackage : bcai_pkg

// [common/bcai_link_if.sv]
`timescale 1ns/10ps
`default_nettype none
`include "bcai_consts.svh"
interface bcai_link_if;
  // serial link, driven by the codec except the downlink data
  logic                      pcmBitClock;
  logic                      pcmFrameSync;
  logic                      codecTxLine;
  logic                      codecRxLine;
  // parallel bus
  logic [`BCAI_ADDR_W-1:0]  busAddr;
  logic                      rdN;
  logic                      wrN;
  logic                      ackN;
  logic [`BCAI_DATA_W-1:0]  codecDataOut;
  logic                      codecDataOe;
  logic [`BCAI_DATA_W-1:0]  dspDataOut;
  logic                      dspDataOe;
  logic [`BCAI_DATA_W-1:0]  busData;

  // resolved data lines, pulled high when nobody drives
  assign busData = dspDataOe ? dspDataOut :
                   (codecDataOe ? codecDataOut : `BCAI_DATA_IDLE);

  modport codec (
    output pcmBitClock, pcmFrameSync, codecTxLine, ackN, codecDataOut, codecDataOe,
    input  codecRxLine, busAddr, rdN, wrN, busData
  );
  modport dsp (
    input  pcmBitClock, pcmFrameSync, codecTxLine, ackN, busData,
    output codecRxLine, busAddr, rdN, wrN, dspDataOut, dspDataOe
  );
endinterface : bcai_link_if
`default_nettype wire

// [hdl/bcai_dsp_end.sv]
`timescale 1ns/10ps
`default_nettype none
`include "bcai_consts.svh"
module bcai_dsp_end (
  input  wire logic                     clk,             // 50 MHz clock
  input  wire logic                     sys_rst,         // async reset, high
  input  wire logic [`BCAI_SAMPLE_W-1:0] downSample,     // downlink sample to send
  input  wire logic                     req,             // bus access request
  input  wire logic                     isWrite,         // request is a write
  input  wire logic [`BCAI_ADDR_W-1:0]  reqAddr,         // word address
  input  wire logic [`BCAI_DATA_W-1:0]  reqData,         // write data
  input  wire logic                     callActive,      // a call is in progress
  output logic      [`BCAI_SAMPLE_W-1:0] upSample,       // received uplink sample
  output logic                          upValid,         // uplink sample pulse
  output logic                          busy,            // access in progress
  output logic                          done,            // access finished pulse
  output logic      [`BCAI_DATA_W-1:0]  rdData,          // read data
  output logic                          detectIrqEnable, // detect interrupt enable
  bcai_link_if.dsp                      lnk              // link to the codec
);

  // serial slave state, clocks taken as inputs
  logic                       clkPrev;
  logic [6:0]                 slot;
  logic [6:0]                 next_slot;
  logic                       rxLine;
  logic                       next_rxLine;
  logic [`BCAI_SAMPLE_W-1:0] txShift;
  logic [`BCAI_SAMPLE_W-1:0] next_txShift;
  logic [`BCAI_SAMPLE_W-1:0] rxShift;
  logic [`BCAI_SAMPLE_W-1:0] next_rxShift;
  logic [`BCAI_SAMPLE_W-1:0] next_upSample;
  logic                       next_upValid;
  logic                       rise;
  logic                       fall;

  assign rise = lnk.pcmBitClock && !clkPrev;   // see RULE3
  assign fall = !lnk.pcmBitClock && clkPrev;

  // drive on rising edge, sample on falling edge
  always_comb begin
    next_slot     = slot;
    next_rxLine   = rxLine;
    next_txShift  = txShift;
    next_rxShift  = rxShift;
    next_upSample = upSample;
    next_upValid  = 1'b0;
    if (rise) begin
      if (lnk.pcmFrameSync) begin
        next_slot    = `BCAI_SLOT_SYNC;                             // see RULE3
        next_txShift = downSample;                                  // see RULE7
        next_rxLine  = 1'b0;
      end else if (slot < `BCAI_SLOT_LAST) begin
        next_slot    = slot + 7'h01;
        next_rxLine  = txShift[`BCAI_SAMPLE_W-1];                   // see RULE11
        next_txShift = {txShift[`BCAI_SAMPLE_W-2:0], 1'b0};
      end else begin
        next_slot   = `BCAI_FRAME_LAST;
        next_rxLine = 1'b0;
      end
    end else if (fall && (slot >= `BCAI_SLOT_FIRST) && (slot <= `BCAI_SLOT_LAST)) begin
      next_rxShift = {rxShift[`BCAI_SAMPLE_W-2:0], lnk.codecTxLine}; // see RULE11
      if (slot == `BCAI_SLOT_LAST) begin
        next_upSample = {rxShift[`BCAI_SAMPLE_W-2:0], lnk.codecTxLine};
        next_upValid  = 1'b1;                                       // see RULE7
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clkPrev  <= 1'b0;
      slot     <= `BCAI_FRAME_LAST;
      rxLine   <= 1'b0;
      txShift  <= `BCAI_SAMPLE_ZERO;
      rxShift  <= `BCAI_SAMPLE_ZERO;
      upSample <= `BCAI_SAMPLE_ZERO;
      upValid  <= 1'b0;
    end else begin
      clkPrev  <= lnk.pcmBitClock;
      slot     <= next_slot;
      rxLine   <= next_rxLine;
      txShift  <= next_txShift;
      rxShift  <= next_rxShift;
      upSample <= next_upSample;
      upValid  <= next_upValid;
    end
  end

  assign lnk.codecRxLine = rxLine;   // see RULE4

  // parallel bus master
  bcai_pkg::bcai_dsp_bus_t  state;
  bcai_pkg::bcai_dsp_bus_t  next_state;
  logic [`BCAI_ADDR_W-1:0] addr;
  logic [`BCAI_ADDR_W-1:0] next_addr;
  logic [`BCAI_DATA_W-1:0] dataOut;
  logic [`BCAI_DATA_W-1:0] next_dataOut;
  logic                     dataOe;
  logic                     next_dataOe;
  logic                     rdN;
  logic                     next_rdN;
  logic                     wrN;
  logic                     next_wrN;
  logic                     next_busy;
  logic                     next_done;
  logic [`BCAI_DATA_W-1:0] next_rdData;

  // strobe low until acknowledged, then wait for acknowledge release
  always_comb begin
    next_state   = state;
    next_addr    = addr;
    next_dataOut = dataOut;
    next_dataOe  = dataOe;
    next_rdN     = rdN;
    next_wrN     = wrN;
    next_done    = 1'b0;
    next_rdData  = rdData;
    case (state)
      bcai_pkg::BCAI_DSP_IDLE: begin
        if (req && lnk.ackN) begin
          next_addr    = reqAddr;                                   // see RULE5
          next_dataOut = reqData;
          next_dataOe  = isWrite;                                   // see RULE6
          next_wrN     = !isWrite;
          next_rdN     = isWrite;
          next_state   = bcai_pkg::BCAI_DSP_STROBE;
        end
      end
      bcai_pkg::BCAI_DSP_STROBE: begin
        if (!lnk.ackN) begin
          if (!rdN)
            next_rdData = lnk.busData;                              // see RULE5
          next_rdN    = 1'b1;
          next_wrN    = 1'b1;
          next_dataOe = 1'b0;
          next_done   = 1'b1;
          next_state  = bcai_pkg::BCAI_DSP_RELEASE;
        end
      end
      bcai_pkg::BCAI_DSP_RELEASE: begin
        if (lnk.ackN)
          next_state = bcai_pkg::BCAI_DSP_IDLE;
      end
      default: begin
        next_rdN    = 1'b1;
        next_wrN    = 1'b1;
        next_dataOe = 1'b0;
        next_state  = bcai_pkg::BCAI_DSP_IDLE;
      end
    endcase
    next_busy = (next_state != bcai_pkg::BCAI_DSP_IDLE);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state           <= bcai_pkg::BCAI_DSP_IDLE;
      addr            <= `BCAI_ADDR_ZERO;
      dataOut         <= `BCAI_DATA_ZERO;
      dataOe          <= 1'b0;
      rdN             <= 1'b1;
      wrN             <= 1'b1;
      busy            <= 1'b0;
      done            <= 1'b0;
      rdData          <= `BCAI_DATA_ZERO;
      detectIrqEnable <= 1'b0;
    end else begin
      state           <= next_state;
      addr            <= next_addr;
      dataOut         <= next_dataOut;
      dataOe          <= next_dataOe;
      rdN             <= next_rdN;
      wrN             <= next_wrN;
      busy            <= next_busy;
      done            <= next_done;
      rdData          <= next_rdData;
      detectIrqEnable <= !callActive;                               // see RULE10
    end
  end

  assign lnk.busAddr    = addr;
  assign lnk.rdN        = rdN;
  assign lnk.wrN        = wrN;
  assign lnk.dspDataOut = dataOut;
  assign lnk.dspDataOe  = dataOe;

endmodule : bcai_dsp_end
`default_nettype wire

// [tb/bcai_link_chk.sv]
`timescale 1ns/10ps
`default_nettype none
`include "bcai_consts.svh"
module bcai_link_chk (
  input  wire logic                    clk,          // 50 MHz clock
  input  wire logic                    sys_rst,      // async reset, high
  input  wire logic                    pcmBitClock,  // serial bit clock
  input  wire logic                    pcmFrameSync, // serial frame sync
  input  wire logic                    codecTxLine,  // uplink serial data
  input  wire logic                    codecRxLine,  // downlink serial data
  input  wire logic [`BCAI_ADDR_W-1:0] busAddr,      // bus address
  input  wire logic                    rdN,          // read strobe
  input  wire logic                    wrN,          // write strobe
  input  wire logic                    ackN,         // acknowledge strobe
  input  wire logic                    codecDataOe,  // codec drives data
  input  wire logic                    dspDataOe     // dsp drives data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [10:0] frameCnt;
  logic [10:0] next_frameCnt;
  logic        syncQ;
  logic        seenSync;
  logic        next_seenSync;
  wire         syncRise = pcmFrameSync & ~syncQ;
  // cycles since the last frame sync rise, one tick per cycle
  always_comb begin
    next_frameCnt = syncRise ? 11'h001 : frameCnt + 11'h001;
    next_seenSync = seenSync | syncRise;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      frameCnt <= 11'h000;
      syncQ    <= 1'b0;
      seenSync <= 1'b0;
    end else begin
      frameCnt <= next_frameCnt;
      syncQ    <= pcmFrameSync;
      seenSync <= next_seenSync;
    end
  end
  bitclk_shape_a: assert property (
    $rose(pcmBitClock) |-> pcmBitClock[*6] ##1 !pcmBitClock[*7] ##1 pcmBitClock)
    else $error("bit clock period is not 6 high and 7 low");
  frame_period_a: assert property (syncRise && seenSync |-> frameCnt == 11'h659)
    else $error("frame sync period is not 125 bit slots");
  sync_slot_a: assert property (
    $rose(pcmFrameSync) |-> $rose(pcmBitClock) ##12 pcmFrameSync ##1 !pcmFrameSync)
    else $error("frame sync does not fill slot zero");
  lines_idle_a: assert property (
    seenSync && frameCnt >= 11'h0E0 |-> !codecTxLine && !codecRxLine)
    else $error("serial data outside data slots");
  write_cycle_a: assert property (
    $fell(wrN) |-> ##1 (!ackN && !wrN) ##1 (wrN && !ackN) ##1 ackN)
    else $error("write handshake out of order");
  read_cycle_a: assert property (
    $fell(rdN) |-> ##1 (!ackN && codecDataOe) ##1 (rdN && !ackN) ##1 (ackN && !codecDataOe))
    else $error("read handshake out of order");
  write_drive_a: assert property (!wrN |-> dspDataOe && !codecDataOe)
    else $error("write data not driven by dsp alone");
  addr_hold_a: assert property ($fell(wrN) || $fell(rdN) |=> $stable(busAddr)[*2])
    else $error("address changed during access");
  one_strobe_a: assert property (!(!rdN && !wrN))
    else $error("both strobes low");
endmodule : bcai_link_chk
`default_nettype wire

// [tb/test_baseband_codec_audio_interface.sv]
`timescale 1ns/10ps
`default_nettype none
`define TB_CHECK(got, exp) begin nCompared++; if ((got) !== (exp)) begin mismatches++; \
  $display("ERROR at %0t: value %h, expected %h", $time, got, exp); end end
module test_baseband_codec_audio_interface;
  logic        clk, sys_rst, rfTick, hookIn, headIn, callActive, irqEn;
  logic        wordLoad, req, isWrite, downValid, upValid, ctrlUpdate, accIrq, busy, done;
  logic [3:0]  wordIndex, reqAddr, ctrlIndex;
  logic [11:0] wordValue, reqData, ctrlValue, rdData, e12;
  logic [12:0] e13;
  logic [15:0] upIn, downIn, upOut, downOut, e16;
  logic [15:0] upQ[$], downQ[$], ctrlQ[$];
  logic [12:0] doneQ[$];
  logic [11:0] mem[16];
  logic [1:0]  pat[8] = '{2'b10, 2'b00, 2'b10, 2'b11, 2'b01, 2'b11, 2'b00, 2'b10};
  bcai_pkg::bcai_accessory_t accessory, ea, irqQ[$];
  int          mismatches = 0;
  int          nCompared = 0;
  bcai_link_if lnk ();
  bcai_codec_end bcai_codec_end_inst (.clk(clk), .sys_rst(sys_rst), .rfTick(rfTick),
    .hookDetectInput(hookIn), .headsetDetectInput(headIn), .detectIrqEnable(irqEn),
    .upSample(upIn), .wordLoad(wordLoad), .wordIndex(wordIndex), .wordValue(wordValue),
    .downSample(downOut), .downValid(downValid), .ctrlUpdate(ctrlUpdate),
    .ctrlIndex(ctrlIndex), .ctrlValue(ctrlValue), .accessoryIrq(accIrq),
    .accessory(accessory), .lnk(lnk));
  bcai_dsp_end bcai_dsp_end_inst (.clk(clk), .sys_rst(sys_rst), .downSample(downIn),
    .req(req), .isWrite(isWrite), .reqAddr(reqAddr), .reqData(reqData),
    .callActive(callActive), .upSample(upOut), .upValid(upValid), .busy(busy),
    .done(done), .rdData(rdData), .detectIrqEnable(irqEn), .lnk(lnk));
  bcai_link_chk bcai_link_chk_inst (.clk(clk), .sys_rst(sys_rst),
    .pcmBitClock(lnk.pcmBitClock), .pcmFrameSync(lnk.pcmFrameSync),
    .codecTxLine(lnk.codecTxLine), .codecRxLine(lnk.codecRxLine), .busAddr(lnk.busAddr),
    .rdN(lnk.rdN), .wrN(lnk.wrN), .ackN(lnk.ackN), .codecDataOe(lnk.codecDataOe),
    .dspDataOe(lnk.dspDataOe));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // decode of hook and headset levels
  function automatic bcai_pkg::bcai_accessory_t acc(input logic [1:0] hd);
    case (hd)
      2'b11: acc = bcai_pkg::BCAI_ACC_NONE;
      2'b00: acc = bcai_pkg::BCAI_ACC_PRESSED;
      2'b10: acc = bcai_pkg::BCAI_ACC_RELEASED;
      default: acc = bcai_pkg::BCAI_ACC_UNKNOWN;
    endcase
  endfunction : acc
  // new random samples for both directions
  task automatic new_words;
    upIn = 16'($urandom);
    downIn = 16'($urandom);
    upQ.push_back(upIn);
    downQ.push_back(downIn);
  endtask : new_words
  // follow k frames, changing samples well after the data slots of each frame but the last
  task automatic frames(input int k);
    int n;
    for (int i = 0; i < k; i++) begin
      n = 0;
      do begin
        @(posedge clk) #1;
        n++;
      end while (lnk.pcmFrameSync !== 1'b1 && n < 2000);
      repeat (400) @(posedge clk) #1;
      if (i < k - 1) new_words();
    end
  endtask : frames
  // one bus access, noting the expected results
  task automatic access(input logic w, input logic [3:0] a, input logic [11:0] d);
    int n;
    if (w) mem[a] = d;
    if (w) ctrlQ.push_back({a, d});
    doneQ.push_back({~w, mem[a]});
    @(posedge clk) #1;
    req = 1'b1;
    isWrite = w;
    reqAddr = a;
    reqData = d;
    @(posedge clk) #1;
    req = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(posedge clk) #1;
      n++;
    end
    if (n == 20) mismatches++;
  endtask : access
  // change the detect inputs and check the decode
  task automatic detect(input logic [1:0] hd);
    repeat (2) @(posedge clk) #1;
    if (!callActive) irqQ.push_back(acc(hd));
    {hookIn, headIn} = hd;
    repeat (3) @(posedge clk) #1;
    `TB_CHECK(accessory, acc(hd))
    `TB_CHECK(irqEn, ~callActive)
  endtask : detect
  // compare each result with the oldest note
  always @(posedge clk) begin
    if (upValid) begin
      e16 = upQ.pop_front();
      `TB_CHECK(upOut, e16)
    end
    if (downValid) begin
      e16 = downQ.pop_front();
      `TB_CHECK(downOut, e16)
    end
    if (ctrlUpdate) begin
      e16 = ctrlQ.pop_front();
      `TB_CHECK({ctrlIndex, ctrlValue}, e16)
    end
    if (done) begin
      e13 = doneQ.pop_front();
      e12 = e13[11:0];
      if (e13[12] !== 1'b0) `TB_CHECK(rdData, e12)
    end
    if (accIrq) begin
      ea = irqQ.pop_front();
      `TB_CHECK(accessory, ea)
    end
  end
  task final_report;
    $display("comparisons %0d, mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  // watchdog for a hung handshake or missing frames
  initial begin
    #(20 * 30000);
    mismatches++;
    final_report();
  end
  // main sequence
  initial begin
    void'($urandom(32'h7B0063FE));
    {sys_rst, rfTick, hookIn, headIn, callActive} = 5'h16;
    {wordLoad, req, isWrite, wordIndex, reqAddr} = 11'h000;
    {wordValue, reqData} = 24'h000000;
    new_words();
    repeat (2) @(posedge clk) #1;
    sys_rst = 1'b0;
    rfTick = 1'b1;
    fork
      frames(6);
      begin
        for (int i = 0; i < 16; i++) access(1'b1, 4'(i), 12'($urandom));
        @(posedge clk) #1;
        wordLoad = 1'b1;
        wordIndex = 4'h5;
        wordValue = 12'($urandom);
        mem[5] = wordValue;
        @(posedge clk) #1;
        wordLoad = 1'b0;
        for (int i = 15; i >= 0; i--) access(1'b0, 4'(i), 12'h000);
        for (int i = 0; i < 8; i++) begin
          if (i == 5) callActive = 1'b1;
          detect(pat[i]);
        end
      end
    join
    `TB_CHECK(upQ.size() + downQ.size() + doneQ.size() + irqQ.size(), 0)
    final_report();
  end
endmodule : test_baseband_codec_audio_interface
`default_nettype wire
